// *** logic/pwr_state_ctrl.sv ***
// Added by the designer: register access over Wishbone and the address map.
`timescale 1ns/1ps
module pwr_state_ctrl #(
  parameter int TICK_CYCLES = pwr_seq_pkg::TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Supply and switch
  input wire logic ac_ok_i,
  input wire logic pwr_switch_i,
  // Wake sources, all active high except the PCI Express line
  input wire logic rtc_alarm_i,
  input wire logic [31:0] rtc_time_i,
  input wire logic network_wake_i,
  input wire logic usb_activity_i,
  input wire logic pcie_wake_n_i,
  input wire logic infrared_remote_input_i,
  input wire logic radio_wake_i,
  // Rails and indicators
  output logic rail_main_en_o,
  output logic rail_standby_en_o,
  output logic ram_self_refresh_o,
  output logic cold_boot_o,
  output logic display_sleep_o,
  output logic led_primary_o,
  output logic led_secondary_o
);

  // Tick counter is 24 bits wide and needs at least two states per tick
  if (TICK_CYCLES < 2 || TICK_CYCLES > 16777215) begin : g_tick_check
    $error("TICK_CYCLES out of range");
  end

  // ===========================================================
  // Register file and bus
  pwr_seq_pkg::ctrl_t ctrl, next_ctrl;
  logic [31:0] wake_time, next_wake_time;
  pwr_seq_pkg::wake_src_t wake_flags, next_wake_flags;
  logic [31:0] next_dat;
  logic next_ack;
  logic bus_req;
  logic [2:0] cmd;
  pwr_seq_pkg::wake_src_t wake_cause;
  pwr_seq_pkg::pstate_t state, next_state;
  logic cold_boot, next_cold_boot;
  logic disp_sleep, next_disp_sleep;
  logic g3_seen, next_g3_seen;
  logic stored_on, next_stored_on;

  // Byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Read data captured in the request's first cycle; ack follows one cycle later
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Writes land on the edge where the master sees ack, data still held then
  logic wr_go;
  logic [31:0] ctrl_word;
  assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

  // Commands only exist for the single cycle a write lands
  always_comb begin
    cmd = 3'h0;
    if (wr_go && wb_adr_i == pwr_seq_pkg::ADDR_CMD && wb_sel_i[0]) begin
      cmd = wb_dat_i[2:0];
    end
  end

  // Register next values; hardware set wins over software clear
  always_comb begin
    next_ctrl = ctrl;
    next_wake_time = wake_time;
    next_wake_flags = wake_flags;
    next_dat = wb_dat_o;
    next_ack = bus_req;
    ctrl_word = merge({24'h00_0000, ctrl}, wb_dat_i, wb_sel_i);
    if (bus_req) begin
      next_dat = 32'h0000_0000;
      if (wb_adr_i == pwr_seq_pkg::ADDR_CTRL) begin
        next_dat = {24'h00_0000, ctrl};
      end else if (wb_adr_i == pwr_seq_pkg::ADDR_STATUS) begin
        next_dat = {25'h000_0000, stored_on, g3_seen, disp_sleep, cold_boot, state};
      end else if (wb_adr_i == pwr_seq_pkg::ADDR_WAKE_TIME) begin
        next_dat = wake_time;
      end else if (wb_adr_i == pwr_seq_pkg::ADDR_WAKE_FLAGS) begin
        next_dat = {25'h000_0000, wake_flags};
      end
    end
    if (wr_go) begin
      if (wb_adr_i == pwr_seq_pkg::ADDR_CTRL) begin
        next_ctrl = ctrl_word[7:0];
      end else if (wb_adr_i == pwr_seq_pkg::ADDR_WAKE_TIME) begin
        next_wake_time = merge(wake_time, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == pwr_seq_pkg::ADDR_WAKE_FLAGS && wb_sel_i[0]) begin
        next_wake_flags = wake_flags & ~wb_dat_i[6:0];
      end
    end
    next_wake_flags = next_wake_flags | wake_cause;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= pwr_seq_pkg::CTRL_RESET;
      wake_time <= 32'h0000_0000;
      wake_flags <= '0;
      wb_dat_o <= 32'h0000_0000;
      wb_ack_o <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      wake_time <= next_wake_time;
      wake_flags <= next_wake_flags;
      wb_dat_o <= next_dat;
      wb_ack_o <= next_ack;
    end
  end

  // ===========================================================
  // Millisecond tick and power-switch timing
  logic [23:0] tick_cnt, next_tick_cnt;
  logic [12:0] press, next_press;
  logic sw_prev, forced, next_forced;
  logic tick, short_rel, long_hit;

  assign tick = (tick_cnt == 24'(TICK_CYCLES - 1));
  assign short_rel = sw_prev && !pwr_switch_i && !forced
                     && press < pwr_seq_pkg::SHORT_PRESS_TICKS;
  assign long_hit = pwr_switch_i && !forced
                    && press > pwr_seq_pkg::LONG_PRESS_TICKS;

  // Counter saturates, so an endless press cannot wrap into a short one
  always_comb begin
    next_tick_cnt = tick ? 24'h00_0000 : tick_cnt + 24'h00_0001;
    next_press = press;
    next_forced = forced;
    if (!pwr_switch_i) begin
      next_press = 13'h0000;
      next_forced = 1'b0;
    end else begin
      if (tick && press != 13'h1FFF) begin
        next_press = press + 13'h0001;
      end
      if (long_hit) begin
        next_forced = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt <= 24'h00_0000;
      press <= 13'h0000;
      sw_prev <= 1'b0;
      forced <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      press <= next_press;
      sw_prev <= pwr_switch_i;
      forced <= next_forced;
    end
  end

  // ===========================================================
  // Wake qualification per sleep state
  logic in_s3, in_s4, in_s5, asleep, deep;
  logic usb_ok;
  pwr_seq_pkg::wake_src_t valid;

  assign in_s3 = (state == pwr_seq_pkg::ST_S3);
  assign in_s4 = (state == pwr_seq_pkg::ST_S4);
  assign in_s5 = (state == pwr_seq_pkg::ST_S5);
  assign asleep = in_s3 || in_s4 || in_s5;
  assign deep = ctrl.deep_sleep_variant && (in_s4 || in_s5);

  // USB: S3 unless after G3; S4/S5 gated by options; never in deep sleep
  always_comb begin
    usb_ok = 1'b0;
    if (!g3_seen && !deep) begin
      usb_ok = in_s3 || (in_s5 && ctrl.usb_s5_fw_en)
               || (in_s4 && ctrl.usb_s5_fw_en && ctrl.usb_s4_os_en);
    end
  end

  // Radio wake input deliberately has no path into any wake term
  always_comb begin
    valid.button = asleep && short_rel;
    valid.rtc_alarm = asleep && rtc_alarm_i;
    valid.wake_time = in_s5 && ctrl.time_wake_en && rtc_time_i == wake_time;
    valid.network = asleep && network_wake_i;
    valid.usb = usb_ok && usb_activity_i;
    valid.pcie = asleep && !pcie_wake_n_i;
    valid.infrared = asleep && !deep && infrared_remote_input_i;
  end

  // ===========================================================
  // Power state machine
  logic rail_main, ram_sr, led_p, led_s;

  always_comb begin
    next_state = state;
    next_cold_boot = cold_boot;
    next_disp_sleep = disp_sleep;
    next_g3_seen = g3_seen;
    next_stored_on = stored_on;
    wake_cause = '0;
    if (!ac_ok_i) begin
      next_state = pwr_seq_pkg::ST_MECH_OFF;
      next_g3_seen = 1'b1;
    end else begin
      case (state)
        pwr_seq_pkg::ST_MECH_OFF: begin
          // Restore on AC return
          if (ctrl.policy == pwr_seq_pkg::POLICY_POWER_ON
              || (ctrl.policy == pwr_seq_pkg::POLICY_LAST && stored_on)) begin
            next_state = pwr_seq_pkg::ST_S0;
            next_cold_boot = 1'b1;
            next_disp_sleep = 1'b0;
          end else begin
            next_state = pwr_seq_pkg::ST_S5;
          end
        end
        pwr_seq_pkg::ST_S0: begin
          next_stored_on = 1'b1;
          if (long_hit || cmd[pwr_seq_pkg::CMD_ENTER_S5]) begin
            next_state = pwr_seq_pkg::ST_S5;
          end else if (short_rel) begin
            next_state = ctrl.button_sleep ? pwr_seq_pkg::ST_S3 : pwr_seq_pkg::ST_S5;
          end else if (cmd[pwr_seq_pkg::CMD_ENTER_S4]) begin
            next_state = pwr_seq_pkg::ST_S4;
          end else if (cmd[pwr_seq_pkg::CMD_ENTER_S3]) begin
            next_state = pwr_seq_pkg::ST_S3;
          end
          if (next_state == pwr_seq_pkg::ST_S5) begin
            next_stored_on = 1'b0;
          end
        end
        pwr_seq_pkg::ST_S3, pwr_seq_pkg::ST_S4, pwr_seq_pkg::ST_S5: begin
          if (long_hit && !in_s5) begin
            next_state = pwr_seq_pkg::ST_S5;
            next_stored_on = 1'b0;
          end else if (valid != '0) begin
            wake_cause = valid;
            next_state = pwr_seq_pkg::ST_S0;
            next_stored_on = 1'b1;
            next_g3_seen = 1'b0;
            next_cold_boot = !in_s3;
            // Background wakes keep the display dark
            next_disp_sleep = !valid.button && !valid.usb && !valid.infrared;
          end
        end
        default: begin
          next_state = pwr_seq_pkg::ST_S5;
        end
      endcase
    end
  end

  // Outputs follow the state being entered
  always_comb begin
    rail_main = (next_state == pwr_seq_pkg::ST_S0);
    ram_sr = (next_state == pwr_seq_pkg::ST_S3);
    led_p = (next_state == pwr_seq_pkg::ST_S0);
    led_s = (next_state == pwr_seq_pkg::ST_S3) && ctrl.led_dual;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= pwr_seq_pkg::ST_MECH_OFF;
      cold_boot <= 1'b1;
      disp_sleep <= 1'b0;
      g3_seen <= 1'b1;
      stored_on <= 1'b0;
      rail_main_en_o <= 1'b0;
      rail_standby_en_o <= 1'b0;
      ram_self_refresh_o <= 1'b0;
      led_primary_o <= 1'b0;
      led_secondary_o <= 1'b0;
    end else begin
      state <= next_state;
      cold_boot <= next_cold_boot;
      disp_sleep <= next_disp_sleep;
      g3_seen <= next_g3_seen;
      stored_on <= next_stored_on;
      rail_main_en_o <= rail_main;
      rail_standby_en_o <= ac_ok_i;
      ram_self_refresh_o <= ram_sr;
      led_primary_o <= led_p;
      led_secondary_o <= led_s;
    end
  end

  assign cold_boot_o = cold_boot;
  assign display_sleep_o = disp_sleep;

endmodule

// *** logic/pwr_seq_pkg.sv ***
package pwr_seq_pkg;

  // ===========================================================
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_WAKE_TIME = 8'h0C;
  localparam logic [7:0] ADDR_WAKE_FLAGS = 8'h10;

  // Command bits, write-only, self clearing
  localparam int CMD_ENTER_S3 = 0;
  localparam int CMD_ENTER_S4 = 1;
  localparam int CMD_ENTER_S5 = 2;

  // Restore policy after AC failure
  localparam logic [1:0] POLICY_STAY_OFF = 2'h0;
  localparam logic [1:0] POLICY_POWER_ON = 2'h1;
  localparam logic [1:0] POLICY_LAST = 2'h2;

  // ===========================================================
  // Control register, bit 7 downward
  typedef struct packed {
    logic time_wake_en;   // bit 7
    logic led_dual;       // bit 6
    logic deep_sleep_variant; // bit 5
    logic usb_s4_os_en;   // bit 4
    logic usb_s5_fw_en;   // bit 3
    logic [1:0] policy;   // bits 2:1
    logic button_sleep;   // bit 0: short press in S0 goes to S3, else S5
  } ctrl_t;
  localparam ctrl_t CTRL_RESET = 8'h42;

  // Wake sources, also the layout of the wake flag register
  typedef struct packed {
    logic infrared;       // bit 6
    logic pcie;           // bit 5
    logic usb;            // bit 4
    logic network;        // bit 3
    logic wake_time;      // bit 2
    logic rtc_alarm;      // bit 1
    logic button;         // bit 0
  } wake_src_t;

  typedef enum logic [2:0] {
    ST_MECH_OFF = 3'b000,
    ST_S5 = 3'b001,
    ST_S0 = 3'b010,
    ST_S3 = 3'b011,
    ST_S4 = 3'b100
  } pstate_t;

  // ===========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int SHORT_PRESS_S = 4;
  localparam int LONG_PRESS_S = 6;
  localparam int TICKS_PER_S = 1000000000 / TICK_NS;
  localparam logic [12:0] SHORT_PRESS_TICKS = 13'(SHORT_PRESS_S * TICKS_PER_S);
  localparam logic [12:0] LONG_PRESS_TICKS = 13'(LONG_PRESS_S * TICKS_PER_S);

endpackage

// *** tb/pwr_state_ctrl_asserts.sv ***
`timescale 1ns/1ps
module pwr_state_ctrl_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic ac_ok_i,
  input wire logic usb_activity_i,
  input wire logic pcie_wake_n_i,
  input wire logic infrared_remote_input_i,
  input wire logic rail_main_en_o,
  input wire logic rail_standby_en_o,
  input wire logic ram_self_refresh_o,
  input wire logic cold_boot_o,
  input wire logic led_primary_o,
  input wire logic led_secondary_o
);
  // ==========
  // Clocking and bus sequences
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  // ==========
  // Bus answer and rail relations
  a_ack_one_pulse: assert property (s_take |=> s_ack_pulse)
    else $error("bus ack not a single pulse after request");
  a_sleep_rails_off: assert property (ram_self_refresh_o |-> !rail_main_en_o)
    else $error("main rail on while in suspend");
  a_ac_loss_dark: assert property (!ac_ok_i |=> !rail_main_en_o && !rail_standby_en_o)
    else $error("rails on without supply");
  // Indicator must not look on while suspended
  a_led_sleep_look: assert property (led_secondary_o |-> ram_self_refresh_o && !led_primary_o)
    else $error("secondary indicator outside suspend");
  a_resume_warm: assert property ($rose(rail_main_en_o) && $past(ram_self_refresh_o) |-> !cold_boot_o)
    else $error("resume from suspend flagged cold");
  a_start_cold: assert property ($rose(rail_main_en_o) && !$past(ram_self_refresh_o) |-> cold_boot_o)
    else $error("start from off not flagged cold");
  // Qualified wake in suspend answers on the next edge
  a_pcie_wake_s3: assert property (ram_self_refresh_o && ac_ok_i && !pcie_wake_n_i |=> rail_main_en_o)
    else $error("express wake ignored in suspend");
  a_ir_wake_s3: assert property (ram_self_refresh_o && ac_ok_i && infrared_remote_input_i |=> rail_main_en_o)
    else $error("infrared wake ignored in suspend");
  // Every wake clears the mechanical-off memory, so after a warm resume USB must wake
  a_usb_wake_s3: assert property (ram_self_refresh_o && ac_ok_i && !cold_boot_o && usb_activity_i |=> rail_main_en_o)
    else $error("usb wake ignored in suspend");
endmodule
bind pwr_state_ctrl pwr_state_ctrl_asserts pwr_state_ctrl_asserts_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .ac_ok_i(ac_ok_i), .usb_activity_i(usb_activity_i),
  .pcie_wake_n_i(pcie_wake_n_i), .infrared_remote_input_i(infrared_remote_input_i),
  .rail_main_en_o(rail_main_en_o), .rail_standby_en_o(rail_standby_en_o),
  .ram_self_refresh_o(ram_self_refresh_o), .cold_boot_o(cold_boot_o),
  .led_primary_o(led_primary_o), .led_secondary_o(led_secondary_o)
);

// *** tb/wake_src_model.sv ***
`timescale 1ns/1ps
module wake_src_model (
  input wire logic clk_i,
  output logic pwr_switch_o,
  output logic rtc_alarm_o,
  output logic network_wake_o,
  output logic usb_activity_o,
  output logic pcie_wake_n_o,
  output logic infrared_remote_input_o,
  output logic radio_wake_o
);
  // ==========
  // Source lines, bit order of the wake flags, radio on top
  logic [7:0] act;
  // All sources idle until a task raises one
  initial begin
    act = 8'h00;
  end
  assign pwr_switch_o = act[0];
  assign rtc_alarm_o = act[1];
  assign network_wake_o = act[3];
  assign usb_activity_o = act[4];
  assign pcie_wake_n_o = !act[5];
  assign infrared_remote_input_o = act[6];
  assign radio_wake_o = act[7];
  // Switch held n clocks; level only, no bounce modelled
  task automatic press(input int n);
    @(posedge clk_i);
    act[0] <= 1'b1;
    repeat (n) @(posedge clk_i);
    act[0] <= 1'b0;
  endtask
  // Source k active for two clocks, then idle again
  task automatic fire(input int k);
    @(posedge clk_i);
    act[k] <= 1'b1;
    repeat (2) @(posedge clk_i);
    act[k] <= 1'b0;
  endtask
endmodule

// *** tb/pwr_state_ctrl_tb.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin \
  compares++; \
  if ((a) !== (b)) begin \
    failures++; \
    $display("mismatch %0t %h %h", $time, (a), (b)); \
  end \
end
module pwr_state_ctrl_tb;
  // ==========
  // Clock, bus and pin state
  logic clk_i;
  logic rst_i;
  logic cyc;
  logic stb;
  logic we;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat;
  logic [31:0] rtc_time;
  logic ac_ok;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack, sw, rtc, net, usb, pcie_n, ir, radio;
  logic rail, stby, ram, cold, disp, ledp, leds;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // Short tick keeps press counts in ticks but the run brief
  pwr_state_ctrl #(.TICK_CYCLES(4)) pwr_state_ctrl_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ac_ok_i(ac_ok), .pwr_switch_i(sw), .rtc_alarm_i(rtc), .rtc_time_i(rtc_time),
    .network_wake_i(net), .usb_activity_i(usb), .pcie_wake_n_i(pcie_n),
    .infrared_remote_input_i(ir), .radio_wake_i(radio), .rail_main_en_o(rail),
    .rail_standby_en_o(stby), .ram_self_refresh_o(ram), .cold_boot_o(cold),
    .display_sleep_o(disp), .led_primary_o(ledp), .led_secondary_o(leds));
  wake_src_model wake_src_model_i (
    .clk_i(clk_i), .pwr_switch_o(sw), .rtc_alarm_o(rtc), .network_wake_o(net),
    .usb_activity_o(usb), .pcie_wake_n_o(pcie_n), .infrared_remote_input_o(ir),
    .radio_wake_o(radio));
  // ==========
  // Bus tasks; request held until ack is seen at an edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s = 4'hf);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic st(input pwr_seq_pkg::pstate_t s);
    bus(1'b0, pwr_seq_pkg::ADDR_STATUS, 32'h0000_0000);
    `CHK(q[2:0], s)
  endtask
  task automatic cmd(input int c);
    bus(1'b1, pwr_seq_pkg::ADDR_CMD, 32'h0000_0001 << c);
  endtask
  task automatic ctl(input logic [31:0] d);
    bus(1'b1, pwr_seq_pkg::ADDR_CTRL, d);
  endtask
  task test_done;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog; the longest press is about 24000 clocks
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      failures++;
      test_done;
    end
  end
  // ==========
  // Main sequence
  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hf;
    wdat = 32'h0000_0000;
    rtc_time = 32'h0000_0000;
    ac_ok = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, pwr_seq_pkg::ADDR_CTRL, 32'h0000_0000);
    `CHK(q, 32'h0000_0042)
    st(pwr_seq_pkg::ST_S0);
    bus(1'b0, 8'h40, 32'h0000_0000);
    `CHK(q, 32'h0000_0000)
    wake_src_model_i.press(100);
    st(pwr_seq_pkg::ST_S5);
    wake_src_model_i.press(100);
    st(pwr_seq_pkg::ST_S0);
    ctl(32'h0000_0059);
    wake_src_model_i.press(100);
    st(pwr_seq_pkg::ST_S3);
    `CHK({leds, rail, ram}, 3'b101)
    wake_src_model_i.press(100);
    st(pwr_seq_pkg::ST_S0);
    `CHK(cold, 1'b0)
    cmd(pwr_seq_pkg::CMD_ENTER_S3);
    wake_src_model_i.fire(1);
    st(pwr_seq_pkg::ST_S0);
    `CHK(disp, 1'b1)
    // Network, usb, express and infrared from suspend
    for (int k = 3; k < 7; k++) begin
      cmd(pwr_seq_pkg::CMD_ENTER_S3);
      wake_src_model_i.fire(k);
      st(pwr_seq_pkg::ST_S0);
    end
    cmd(pwr_seq_pkg::CMD_ENTER_S3);
    wake_src_model_i.fire(7);
    st(pwr_seq_pkg::ST_S3);
    wake_src_model_i.press(100);
    ctl(32'h0000_0051);
    cmd(pwr_seq_pkg::CMD_ENTER_S5);
    wake_src_model_i.fire(4);
    st(pwr_seq_pkg::ST_S5);
    wake_src_model_i.fire(5);
    st(pwr_seq_pkg::ST_S0);
    ctl(32'h0000_0079);
    cmd(pwr_seq_pkg::CMD_ENTER_S4);
    wake_src_model_i.fire(4);
    st(pwr_seq_pkg::ST_S4);
    wake_src_model_i.fire(6);
    st(pwr_seq_pkg::ST_S4);
    wake_src_model_i.fire(5);
    `CHK(cold, 1'b1)
    bus(1'b1, pwr_seq_pkg::ADDR_WAKE_TIME, 32'h1234_5678);
    ctl(32'h0000_0080);
    cmd(pwr_seq_pkg::CMD_ENTER_S5);
    rtc_time <= 32'h1234_5678;
    st(pwr_seq_pkg::ST_S0);
    rtc_time <= 32'h0000_0000;
    // Every source but radio has woken the system once; flags are sticky until cleared
    bus(1'b0, pwr_seq_pkg::ADDR_WAKE_FLAGS, 32'h0000_0000);
    `CHK(q, 32'h0000_007F)
    bus(1'b1, pwr_seq_pkg::ADDR_WAKE_FLAGS, 32'h0000_0044);
    bus(1'b0, pwr_seq_pkg::ADDR_WAKE_FLAGS, 32'h0000_0000);
    `CHK(q, 32'h0000_003B)
    // Byte lane write touches only its own byte of the wake time
    bus(1'b1, pwr_seq_pkg::ADDR_WAKE_TIME, 32'h0000_AB00, 4'h2);
    bus(1'b0, pwr_seq_pkg::ADDR_WAKE_TIME, 32'h0000_0000);
    `CHK(q, 32'h1234_AB78)
    wake_src_model_i.press(18000);
    st(pwr_seq_pkg::ST_S0);
    wake_src_model_i.press(24040);
    st(pwr_seq_pkg::ST_S5);
    ctl(32'h0000_0004);
    wake_src_model_i.press(100);
    st(pwr_seq_pkg::ST_S0);
    ac_ok <= 1'b0;
    repeat (3) @(posedge clk_i);
    `CHK({rail, stby}, 2'b00)
    ac_ok <= 1'b1;
    repeat (3) @(posedge clk_i);
    st(pwr_seq_pkg::ST_S0);
    `CHK({ledp, rail, cold}, 3'b111)
    // USB stays deaf after mechanical off until some other wake
    cmd(pwr_seq_pkg::CMD_ENTER_S3);
    wake_src_model_i.fire(4);
    st(pwr_seq_pkg::ST_S3);
    wake_src_model_i.press(100);
    st(pwr_seq_pkg::ST_S0);
    test_done;
  end
endmodule
